// ===== hw/pmnv_cfg.svh
/*
 * Offsets, field positions, fixed values and timing counts of the
 * nonvolatile status and slave-address register logic.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef PMNV_CFG_SVH
`define PMNV_CFG_SVH

// Register image held in the device, offsets 0x00 to 0x10.
`define PMNV_IMG_WORDS      17
`define PMNV_IMG_LAST       5'h10
`define PMNV_ADDR_W         5

// Register offsets.
`define PMNV_OFS_SLAVE_ADDR 5'h0d
`define PMNV_OFS_BURN_CTRL  5'h0e
`define PMNV_OFS_PASSWORD   5'h11
`define PMNV_OFS_STATUS     5'h12
`define PMNV_OFS_PAGE       5'h13

// Field positions.
`define PMNV_BURN_BIT       5
`define PMNV_CRC_BIT        3
`define PMNV_RAIL2_IDX      1
`define PMNV_RAIL3_IDX      2

// Fixed upper slave-address bits A7 and A6.
`define PMNV_ADDR_TOP       2'h3

// Burn password; the value is arbitrary.
`define PMNV_PASSWORD       8'h5a

// Burn duration: 100 ms at 250 MHz.
`define PMNV_BURN_TIME_MS   100
`define PMNV_CLK_KHZ        250000
`define PMNV_BURN_CYCLES    `PMNV_TMR_W'(`PMNV_BURN_TIME_MS * `PMNV_CLK_KHZ)
`define PMNV_TMR_W          25

`endif

// ===== hw/pmnv_pkg.sv
/*
 * Types shared by the nonvolatile status register logic.
 * Assumes the constants header is compiled alongside.
 */
package pmnv_pkg;

	// Burn sequencer states, Gray coded along idle, copy, wait, done.
	typedef enum logic [1:0] {
		PMNV_IDLE = 2'h0,
		PMNV_COPY = 2'h1,
		PMNV_WAIT = 2'h3,
		PMNV_DONE = 2'h2
	} pmnv_burn_state_type;

endpackage : pmnv_pkg

// ===== hw/pmnv_burn_seq.sv
/*
 * Burn sequencer: streams the register image to the nonvolatile store
 * and then waits until the programming time, counted from the start of the copy, has elapsed before reporting completion.
 * Assumes the store accepts one word per enabled cycle.
 */
`timescale 1ns/1ps
`include "pmnv_cfg.svh"

module pmnv_burn_seq #(
	parameter logic [`PMNV_TMR_W-1:0] BURN_CYCLES = `PMNV_BURN_CYCLES
) (
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	input  wire logic                    ce,
	input  wire logic                    start,
	output logic                         busy,
	output logic                         done,
	output logic                         copy_en,
	output logic [`PMNV_ADDR_W-1:0]      copy_idx
);

	pmnv_pkg::pmnv_burn_state_type       state;
	pmnv_pkg::pmnv_burn_state_type       next_state;
	logic [`PMNV_TMR_W-1:0]              timer;
	wire                                 last_word;
	wire                                 timer_out;

	assign last_word = (copy_idx == `PMNV_IMG_LAST);
	assign timer_out = (timer >= BURN_CYCLES - 1'b1);
	assign busy      = (state != pmnv_pkg::PMNV_IDLE);
	assign done      = (state == pmnv_pkg::PMNV_DONE);
	assign copy_en   = (state == pmnv_pkg::PMNV_COPY);

	always_comb
	begin
		case (state)
			pmnv_pkg::PMNV_IDLE:
				next_state = start ? pmnv_pkg::PMNV_COPY : pmnv_pkg::PMNV_IDLE;
			pmnv_pkg::PMNV_COPY:
				next_state = last_word ? pmnv_pkg::PMNV_WAIT : pmnv_pkg::PMNV_COPY;
			pmnv_pkg::PMNV_WAIT:
				next_state = timer_out ? pmnv_pkg::PMNV_DONE : pmnv_pkg::PMNV_WAIT;
			pmnv_pkg::PMNV_DONE:
				next_state = pmnv_pkg::PMNV_IDLE;
			default:
				next_state = pmnv_pkg::PMNV_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state    <= pmnv_pkg::PMNV_IDLE;
			timer    <= '0;
			copy_idx <= '0;
		end
		else if (ce)
		begin
			state    <= next_state;
			copy_idx <= copy_en ? copy_idx + 1'b1 : '0;
			timer    <= busy ? timer + 1'b1 : '0;
		end
	end

endmodule : pmnv_burn_seq

// ===== hw/pmnv_regs.sv
/*
 * System and status register logic of a four-rail buck controller:
 * register image, password-gated burn to nonvolatile storage, live
 * status, page index, slave-address selection and the secondary
 * supply gating of rails 2 and 3.
 * Assumes a byte-level I2C front end on ref_clk that presents decoded
 * slave-address bytes and register accesses, a nonvolatile store that
 * presents its image at reset, and rst_n driven by main-supply lockout.
 */
// Behaviour
// [R1] Secondary lockout turns rails 2 and 3 off; release turns both on.
// [R2] Thermal shutdown never resets any register.
// [R3] Bit 5 of 0x0E, reset 0, starts a burn when written 1.
// [R4] Writes are refused during a burn; reads still served; burn ~100 ms.
// [R5] Burn trigger bit clears itself when the burn completes.
// [R6] Page index increments by one after each completed burn.
// [R7] Master should rewrite registers 0x00 to 0x10 before a burn.
// [R8] Trigger write accepted only after correct password written to 0x11.
// [R9] Status 0x12 bits 7 to 4 show rail 1 to 4 power good; code puts rail 4 at bit 7, rail 1 at bit 4.
// [R10] Power-good and thermal bits are live, never latched.
// [R11] Status bit 3 reads 1 while die is above 120 degrees.
// [R12] Status bit 2 reads 1 while in thermal shutdown.
// [R13] Bit 3 of 0x13 flags a bad or blank nonvolatile page.
// [R14] Bits 2:0 of 0x13 hold the current page index.
// [R15] Address byte is seven address bits and direction; match seven.
// [R16] In address-pin mode pin band gives A2:A1, register gives A5:A3.
// [R17] Pin bands select addresses 68h, 69h, 6Ah and 6Bh.
// [R18] Otherwise A5 to A1 come from bits 4:0 of register 0x0D.
// [R19] A7 and A6 are fixed at one.
// [R20] Default slave address is 68h.
// [R21] A changed register address takes effect at once.
// [R22] Main lockout resets all registers; secondary lockout does not.
// [R23] Register reset values load from the nonvolatile image.
// [R24] Password is a constant and unlocks only the next trigger write.
// [R25] Pin band arrives as a two-bit code, sampled while bus idles.
`timescale 1ns/1ps
`include "pmnv_cfg.svh"

module pmnv_regs #(
	parameter logic [`PMNV_TMR_W-1:0] BURN_CYCLES = `PMNV_BURN_CYCLES
) (
	input  wire logic                          ref_clk,
	input  wire logic                          rst_n,
	input  wire logic                          ce,
	// Slave-address byte from the I2C front end.
	input  wire logic                          addr_valid,
	input  wire logic [7:0]                    addr_byte,
	output logic                               addr_hit,
	output logic                               addr_read,
	input  wire logic                          bus_idle,
	// Register access from the I2C front end.
	input  wire logic                          wr_req,
	input  wire logic [7:0]                    reg_addr,
	input  wire logic [7:0]                    wr_data,
	output logic                               wr_ack,
	output logic                               wr_nack,
	input  wire logic                          rd_req,
	output logic                               rd_valid,
	output logic [7:0]                         rd_data,
	// Pins and analog comparators.
	input  wire logic [3:0]                    rail_good_pin,
	input  wire logic                          die_heat_pin,
	input  wire logic                          thermal_shutdown_pin,
	input  wire logic                          secondary_supply_ok_pin,
	input  wire logic [1:0]                    addr_band_pin,
	input  wire logic                          gpio_is_addr,
	// Rail enables from the sequencer and gated enables out.
	input  wire logic [3:0]                    rail_en_seq,
	output logic [3:0]                         rail_en,
	// Nonvolatile store.
	input  wire logic [8*`PMNV_IMG_WORDS-1:0]  nv_image,
	input  wire logic [2:0]                    nv_page_init,
	input  wire logic                          nv_crc_err,
	input  wire logic                          nv_blank,
	output logic                               nv_wr_en,
	output logic [`PMNV_ADDR_W-1:0]            nv_wr_addr,
	output logic [7:0]                         nv_wr_data,
	output logic                               nv_burn_busy
);

	////////////////////////////////////////////////////////////////////
	// Storage and declarations.

	logic [7:0]                    image [0:`PMNV_IMG_WORDS-1];
	logic [2:0]                    nv_page_number;
	logic                          burn_unlock;
	logic [3:0]                    good_meta;
	logic [3:0]                    good_sync;
	logic [2:0]                    misc_meta;
	logic [2:0]                    misc_sync;
	logic [1:0]                    band_meta;
	logic [1:0]                    band_sync;
	logic [1:0]                    addr_band;
	logic [3:0]                    rail_en_q;
	wire                           burn_busy;
	wire                           burn_done;
	wire                           copy_en;
	wire [`PMNV_ADDR_W-1:0]        copy_idx;
	wire                           wr_take;
	wire                           wr_image;
	wire                           wr_burn_ctrl;
	wire                           wr_password;
	wire                           burn_start;
	wire [7:0]                     burn_ctrl_wdata;
	wire [6:0]                     slave_addr;
	wire [4:0]                     addr_field;
	wire                           die_heat_alert;
	wire                           thermal_shutdown_flag;
	wire                           secondary_supply;
	wire [7:0]                     status_byte;
	wire [7:0]                     page_byte;
	wire [7:0]                     next_rd_data;
	wire [3:0]                     rail2_3_mask;

	// True when a register offset falls inside the held image.
	function automatic logic in_image(input logic [7:0] ofs);
		in_image = (ofs <= {3'h0, `PMNV_IMG_LAST});
	endfunction : in_image

	// Byte of the flattened nonvolatile image at a given offset.
	function automatic logic [7:0] nv_byte(
		input logic [8*`PMNV_IMG_WORDS-1:0] img,
		input int                            idx
	);
		nv_byte = img[8*idx +: 8];
	endfunction : nv_byte

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			good_meta <= 4'h0;
			good_sync <= 4'h0;
			misc_meta <= 3'h0;
			misc_sync <= 3'h0;
			band_meta <= 2'h0;
			band_sync <= 2'h0;
		end
		else if (ce)
		begin
			good_meta <= rail_good_pin;
			good_sync <= good_meta;
			misc_meta <= {secondary_supply_ok_pin, thermal_shutdown_pin,
				die_heat_pin};
			misc_sync <= misc_meta;
			band_meta <= addr_band_pin;
			band_sync <= band_meta;
		end
	end

	assign die_heat_alert        = misc_sync[0];
	assign thermal_shutdown_flag = misc_sync[1];
	assign secondary_supply      = misc_sync[2];

	////////////////////////////////////////////////////////////////////
	// Burn sequencer.

	pmnv_burn_seq #(
		.BURN_CYCLES (BURN_CYCLES)
	) u_burn (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.start    (burn_start),
		.busy     (burn_busy),
		.done     (burn_done),
		.copy_en  (copy_en),
		.copy_idx (copy_idx)
	);

	////////////////////////////////////////////////////////////////////
	// Write decode.

	// [R4] Refuse writes while burning.
	assign wr_take      = wr_req && !burn_busy;
	assign wr_ack       = wr_take;
	assign wr_nack      = wr_req && burn_busy;
	assign wr_image     = wr_take && in_image(reg_addr);
	assign wr_burn_ctrl = wr_take && (reg_addr == {3'h0, `PMNV_OFS_BURN_CTRL});
	assign wr_password  = wr_take && (reg_addr == {3'h0, `PMNV_OFS_PASSWORD});

	// [R8] Password gates trigger.
	assign burn_ctrl_wdata = {wr_data[7:`PMNV_BURN_BIT+1],
		wr_data[`PMNV_BURN_BIT] & burn_unlock,
		wr_data[`PMNV_BURN_BIT-1:0]};

	// [R3] Trigger starts burn.
	assign burn_start = wr_burn_ctrl && burn_ctrl_wdata[`PMNV_BURN_BIT];

	////////////////////////////////////////////////////////////////////
	// Register image.

	// [R22] Reset only by main lockout.
	// [R2] Thermal events never reset.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			// [R23] Defaults from store image.
			for (int i = 0; i < `PMNV_IMG_WORDS; i++)
			begin
				image[i] <= nv_byte(nv_image, i);
			end
			// [R3] Trigger resets clear.
			image[`PMNV_OFS_BURN_CTRL][`PMNV_BURN_BIT] <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_burn_ctrl)
			begin
				image[`PMNV_OFS_BURN_CTRL] <= burn_ctrl_wdata;
			end
			else if (wr_image)
			begin
				image[reg_addr[`PMNV_ADDR_W-1:0]] <= wr_data;
			end
			// [R5] Trigger self-clears.
			if (burn_done)
			begin
				image[`PMNV_OFS_BURN_CTRL][`PMNV_BURN_BIT] <= 1'b0;
			end
		end
	end

	// [R24] Unlock lasts one trigger write.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			burn_unlock <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_password)
			begin
				burn_unlock <= (wr_data == `PMNV_PASSWORD);
			end
			else if (wr_burn_ctrl)
			begin
				burn_unlock <= 1'b0;
			end
		end
	end

	// [R6] Page index advances.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			nv_page_number <= nv_page_init;
		end
		else if (ce && burn_done)
		begin
			nv_page_number <= nv_page_number + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Image copy to the store; the trigger bit is stored as zero.

	assign nv_burn_busy = burn_busy;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			nv_wr_en   <= 1'b0;
			nv_wr_addr <= '0;
			nv_wr_data <= 8'h00;
		end
		else if (ce)
		begin
			nv_wr_en   <= copy_en;
			nv_wr_addr <= copy_idx;
			nv_wr_data <= (copy_idx == `PMNV_OFS_BURN_CTRL) ?
				(image[copy_idx] & ~(8'h01 << `PMNV_BURN_BIT)) :
				image[copy_idx];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read path.

	// [R9] Rail good bits.
	// [R10] Live values.
	// [R11] Heat alert bit.
	// [R12] Shutdown bit.
	assign status_byte = {good_sync, die_heat_alert, thermal_shutdown_flag,
		2'h0};

	// [R13] Bad or blank page.
	// [R14] Page index field.
	assign page_byte = {4'h0, nv_crc_err | nv_blank, nv_page_number};

	assign next_rd_data =
		in_image(reg_addr) ? image[reg_addr[`PMNV_ADDR_W-1:0]] :
		(reg_addr == {3'h0, `PMNV_OFS_STATUS}) ? status_byte :
		(reg_addr == {3'h0, `PMNV_OFS_PAGE})   ? page_byte :
		8'h00;

	// [R4] Reads served while burning.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			rd_valid <= 1'b0;
			rd_data  <= 8'h00;
		end
		else if (ce)
		begin
			rd_valid <= rd_req;
			if (rd_req)
			begin
				rd_data <= next_rd_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Slave-address selection.

	// [R25] Band sampled on idle bus.
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			addr_band <= 2'h0;
		end
		else if (ce && bus_idle)
		begin
			addr_band <= band_sync;
		end
	end

	// [R16] Pin mode mixes sources.
	// [R17] Band code gives A2:A1.
	// [R18] Register mode field.
	assign addr_field = gpio_is_addr ?
		{image[`PMNV_OFS_SLAVE_ADDR][4:2], addr_band} :
		image[`PMNV_OFS_SLAVE_ADDR][4:0];

	// [R19] Fixed top bits.
	// [R20] Default field gives 68h.
	// [R21] Image feeds match directly.
	assign slave_addr = {`PMNV_ADDR_TOP, addr_field};

	// [R15] Match seven bits only.
	assign addr_hit  = addr_valid && (addr_byte[7:1] == slave_addr);
	assign addr_read = addr_byte[0];

	////////////////////////////////////////////////////////////////////
	// Secondary supply gating of rails 2 and 3.

	// [R1] Both rails drop and rise together.
	assign rail2_3_mask = secondary_supply ? 4'hf :
		~((4'h1 << `PMNV_RAIL2_IDX) | (4'h1 << `PMNV_RAIL3_IDX));

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			rail_en_q <= 4'h0;
		end
		else if (ce)
		begin
			rail_en_q <= rail_en_seq & rail2_3_mask;
		end
	end

	assign rail_en = rail_en_q;

endmodule : pmnv_regs

// ===== sim/pmnv_regs_asserts.sv
/* Port checker of the nonvolatile status register block.
   Assumes ce stays high and a single clock domain. */
`timescale 1ns/1ps
`include "pmnv_cfg.svh"
module pmnv_regs_asserts #(
	parameter logic [`PMNV_TMR_W-1:0] BURN_CYCLES = `PMNV_BURN_CYCLES
) (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       wr_req,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] wr_data,
	input wire logic       wr_ack,
	input wire logic       wr_nack,
	input wire logic       rd_req,
	input wire logic       rd_valid,
	input wire logic [7:0] rd_data,
	input wire logic       addr_valid,
	input wire logic [7:0] addr_byte,
	input wire logic       addr_hit,
	input wire logic [3:0] rail_good_pin,
	input wire logic       die_heat_pin,
	input wire logic       thermal_shutdown_pin,
	input wire logic       secondary_supply_ok_pin,
	input wire logic [3:0] rail_en_seq,
	input wire logic [3:0] rail_en,
	input wire logic       nv_wr_en,
	input wire logic       nv_burn_busy
);
	logic [5:0] stat;
	assign stat = {rail_good_pin, die_heat_pin, thermal_shutdown_pin};
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////
	sequence s_unlock;
		wr_ack && reg_addr == 8'h11 && wr_data == `PMNV_PASSWORD ##1
		!wr_req ##1 wr_ack && reg_addr == 8'h0e && wr_data[5];
	endsequence
	AST_WR_NACK: assert property (
		wr_req && nv_burn_busy |-> wr_nack && !wr_ack)
		else $error("write not refused during burn");
	AST_WR_ACK: assert property (
		wr_req && !nv_burn_busy |-> wr_ack && !wr_nack)
		else $error("write not accepted while idle");
	AST_RD_SERVED: assert property (
		rd_req ##1 !rd_req |-> rd_valid ##1 !rd_valid)
		else $error("read not answered with one valid pulse");
	AST_PWD_HIDDEN: assert property (
		rd_req && reg_addr == 8'h11 |=> rd_data == 8'h00)
		else $error("password register readable");
	AST_ADDR_TOP: assert property (
		addr_hit |-> addr_valid && addr_byte[7:6] == 2'h3)
		else $error("match with upper address bits not one");
	AST_RAIL_OFF: assert property (
		!secondary_supply_ok_pin [*3] |=> rail_en[2:1] == 2'h0)
		else $error("rails two and three on during lockout");
	AST_RAIL_ON: assert property (
		(rst_n && secondary_supply_ok_pin) [*3]
		|=> rail_en == $past(rail_en_seq))
		else $error("rail enables differ from sequencer");
	AST_BURN_START: assert property (
		s_unlock |=> nv_burn_busy)
		else $error("unlocked trigger did not start burn");
	AST_COPY: assert property (
		$rose(nv_burn_busy) |=> nv_wr_en [*8])
		else $error("image copy not streamed");
	AST_BURN_END: assert property (
		$rose(nv_burn_busy) |-> ##[17:1000] !nv_burn_busy)
		else $error("burn did not finish");
	AST_STATUS: assert property (
		rd_req && reg_addr == 8'h12 && $past(rst_n, 2) && $past(rst_n)
		&& $past(stat) == stat && $past(stat, 2) == stat
		|=> rd_data[7:2] == $past(stat))
		else $error("status bits differ from pins");
	cover property (s_unlock);
	cover property ($fell(nv_burn_busy));
	cover property (addr_hit);
endmodule : pmnv_regs_asserts

bind pmnv_regs pmnv_regs_asserts #(.BURN_CYCLES(BURN_CYCLES)) u_asserts (
	.ref_clk(ref_clk), .rst_n(rst_n), .wr_req(wr_req),
	.reg_addr(reg_addr), .wr_data(wr_data), .wr_ack(wr_ack),
	.wr_nack(wr_nack), .rd_req(rd_req), .rd_valid(rd_valid),
	.rd_data(rd_data), .addr_valid(addr_valid), .addr_byte(addr_byte),
	.addr_hit(addr_hit), .rail_good_pin(rail_good_pin),
	.die_heat_pin(die_heat_pin),
	.thermal_shutdown_pin(thermal_shutdown_pin),
	.secondary_supply_ok_pin(secondary_supply_ok_pin),
	.rail_en_seq(rail_en_seq), .rail_en(rail_en),
	.nv_wr_en(nv_wr_en), .nv_burn_busy(nv_burn_busy)
);

// ===== sim/pmnv_master_model.sv
/* Bus master side of the byte-level front end: address bytes and
   register accesses. Assumes requests are taken on rising ref_clk. */
`timescale 1ns/1ps
module pmnv_master_model (
	input wire logic       ref_clk,
	output logic           addr_valid,
	output logic [7:0]     addr_byte,
	input wire logic       addr_hit,
	output logic           wr_req,
	output logic [7:0]     reg_addr,
	output logic [7:0]     wr_data,
	input wire logic       wr_ack,
	input wire logic       wr_nack,
	output logic           rd_req,
	input wire logic       rd_valid,
	input wire logic [7:0] rd_data
);
	initial
	begin
		addr_valid = 1'b0;
		addr_byte = 8'h00;
		wr_req = 1'b0;
		reg_addr = 8'h00;
		wr_data = 8'h00;
		rd_req = 1'b0;
	end
////////////////////////////////////////////////////////////////////////
	// Address then direction.
	task automatic addr(input logic [7:0] b, output logic hit);
		@(posedge ref_clk);
		addr_valid <= 1'b1;
		addr_byte <= b;
		@(posedge ref_clk);
		hit = addr_hit;
		addr_valid <= 1'b0;
		addr_byte <= ~b;
	endtask : addr
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		wr_req <= 1'b1;
		reg_addr <= a;
		wr_data <= d;
		@(posedge ref_clk);
		r = {wr_ack, wr_nack};
		wr_req <= 1'b0;
		reg_addr <= ~a;
		wr_data <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge ref_clk);
		rd_req <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		rd_req <= 1'b0;
		reg_addr <= ~a;
		@(posedge ref_clk);
		v = rd_valid;
		d = rd_data;
	endtask : rd
endmodule : pmnv_master_model

// ===== sim/pmnv_regs_tb_top.sv
/* Self-checking bench of the nonvolatile status register block.
   Assumes the design, checker and master model are compiled first. */
`timescale 1ns/1ps
`include "pmnv_cfg.svh"
module pmnv_regs_tb_top;
	localparam logic [`PMNV_TMR_W-1:0] BURN = 25'h14;
	logic ref_clk, rst_n, ce, bus_idle, gpio_is_addr, die_heat_pin;
	logic thermal_shutdown_pin, secondary_supply_ok_pin;
	logic nv_crc_err, nv_blank, nv_wr_en, nv_burn_busy;
	logic addr_valid, addr_hit, addr_read, wr_req, wr_ack, wr_nack;
	logic rd_req, rd_valid;
	logic [1:0] addr_band_pin;
	logic [2:0] nv_page_init;
	logic [3:0] rail_good_pin, rail_en_seq, rail_en;
	logic [4:0] nv_wr_addr;
	logic [7:0] addr_byte, reg_addr, wr_data, rd_data, nv_wr_data;
	logic [135:0] nv_image;
	logic [5:0] pat [3] = '{6'h2b, 6'h15, 6'h00};
	int mismatches, checks, pulses;
	pmnv_regs #(.BURN_CYCLES(BURN)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.ce(ce), .addr_valid(addr_valid), .addr_byte(addr_byte),
		.addr_hit(addr_hit), .addr_read(addr_read), .bus_idle(bus_idle),
		.wr_req(wr_req), .reg_addr(reg_addr), .wr_data(wr_data),
		.wr_ack(wr_ack), .wr_nack(wr_nack), .rd_req(rd_req),
		.rd_valid(rd_valid), .rd_data(rd_data),
		.rail_good_pin(rail_good_pin), .die_heat_pin(die_heat_pin),
		.thermal_shutdown_pin(thermal_shutdown_pin),
		.secondary_supply_ok_pin(secondary_supply_ok_pin),
		.addr_band_pin(addr_band_pin), .gpio_is_addr(gpio_is_addr),
		.rail_en_seq(rail_en_seq), .rail_en(rail_en), .nv_image(nv_image),
		.nv_page_init(nv_page_init), .nv_crc_err(nv_crc_err),
		.nv_blank(nv_blank), .nv_wr_en(nv_wr_en), .nv_wr_addr(nv_wr_addr),
		.nv_wr_data(nv_wr_data), .nv_burn_busy(nv_burn_busy));
	pmnv_master_model master (.ref_clk(ref_clk), .addr_valid(addr_valid),
		.addr_byte(addr_byte), .addr_hit(addr_hit), .wr_req(wr_req),
		.reg_addr(reg_addr), .wr_data(wr_data), .wr_ack(wr_ack),
		.wr_nack(wr_nack), .rd_req(rd_req), .rd_valid(rd_valid),
		.rd_data(rd_data));
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		if (nv_wr_en === 1'b1)
		begin
			chk("store address", pulses[7:0], {3'h0, nv_wr_addr});
			chk("store data", (pulses == 14) ? 8'h01 :
				nv_image[8*pulses +: 8], nv_wr_data);
			pulses <= pulses + 1;
		end
////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask : chk
	task wchk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
		logic [1:0] r;
		master.wr(a, d, r);
		chk("write response", {6'h00, e}, {6'h00, r});
	endtask : wchk
	task rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		master.rd(a, d, v);
		chk("read valid", 8'h01, {7'h00, v});
		chk("read data", e, d & m);
	endtask : rchk
	task achk(input logic [7:0] b, input logic e);
		logic h;
		master.addr(b, h);
		chk("address match", {7'h00, e}, {7'h00, h});
		chk("direction bit", {7'h00, b[0]}, {7'h00, addr_read});
	endtask : achk
	task results;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	task t_reset;
		rchk(8'h0d, 8'hff, 8'h08);
		rchk(8'h0e, 8'hff, 8'h01);
		rchk(8'h00, 8'hff, 8'ha5);
		rchk(8'h11, 8'hff, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			nv_crc_err <= k[0];
			nv_blank <= k[1];
			rchk(8'h13, 8'h0f, {4'h0, |k[1:0], 3'h1});
		end
		$display("reset test done");
	endtask : t_reset
	task t_status;
		wchk(8'h0d, 8'h0b, 2'h2);
		for (int k = 0; k < 3; k++)
		begin
			{rail_good_pin, die_heat_pin, thermal_shutdown_pin} <= pat[k];
			repeat (3) @(posedge ref_clk);
			rchk(8'h12, 8'hfc, {pat[k], 2'h0});
		end
		rchk(8'h0d, 8'hff, 8'h0b);
		wchk(8'h0d, 8'h08, 2'h2);
		$display("status test done");
	endtask : t_status
	task t_addr;
		achk(8'hd0, 1'b1);
		achk(8'hd1, 1'b1);
		achk(8'hd2, 1'b0);
		achk(8'h50, 1'b0);
		gpio_is_addr <= 1'b1;
		for (int b = 0; b < 4; b++)
		begin
			addr_band_pin <= b[1:0];
			repeat (4) @(posedge ref_clk);
			achk(8'hd0 + {b[1:0], 1'b0}, 1'b1);
			achk((8'hd0 + {b[1:0], 1'b0}) ^ 8'h02, 1'b0);
		end
		bus_idle <= 1'b0;
		addr_band_pin <= 2'h0;
		repeat (4) @(posedge ref_clk);
		achk(8'hd6, 1'b1);
		bus_idle <= 1'b1;
		repeat (4) @(posedge ref_clk);
		achk(8'hd0, 1'b1);
		wchk(8'h0d, 8'h10, 2'h2);
		achk(8'he0, 1'b1);
		gpio_is_addr <= 1'b0;
		wchk(8'h0d, 8'h0b, 2'h2);
		achk(8'hd6, 1'b1);
		achk(8'hd0, 1'b0);
		wchk(8'h0d, 8'h08, 2'h2);
		$display("address test done");
	endtask : t_addr
	task t_burn;
		int n;
		for (int i = 0; i < 17; i++)
			wchk(i[7:0], (i == 14) ? 8'h01 : nv_image[8*i +: 8],
				2'h2);
		wchk(8'h0e, 8'h21, 2'h2);
		rchk(8'h0e, 8'hff, 8'h01);
		wchk(8'h11, 8'h00, 2'h2);
		wchk(8'h0e, 8'h21, 2'h2);
		rchk(8'h0e, 8'hff, 8'h01);
		pulses = 0;
		wchk(8'h11, `PMNV_PASSWORD, 2'h2);
		wchk(8'h0e, 8'h21, 2'h2);
		rchk(8'h0e, 8'hff, 8'h21);
		wchk(8'h0d, 8'h0b, 2'h1);
		n = 0;
		while (nv_burn_busy !== 1'b0 && n < 1000)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 1000)
		begin
			$display("ERROR burn end expected 0 seen 1");
			mismatches++;
			results;
		end
		chk("copied words", 8'h11, pulses[7:0]);
		rchk(8'h0e, 8'hff, 8'h01);
		rchk(8'h13, 8'h07, 8'h02);
		rchk(8'h0d, 8'hff, 8'h08);
		wchk(8'h0e, 8'h21, 2'h2);
		rchk(8'h0e, 8'hff, 8'h01);
		$display("burn test done");
	endtask : t_burn
	task t_rails;
		rail_en_seq <= 4'hd;
		secondary_supply_ok_pin <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk("rail enables", 8'h09, {4'h0, rail_en});
		rchk(8'h0d, 8'hff, 8'h08);
		secondary_supply_ok_pin <= 1'b1;
		repeat (5) @(posedge ref_clk);
		chk("rail enables", 8'h0d, {4'h0, rail_en});
		$display("rail test done");
	endtask : t_rails
	task t_reset2;
		wchk(8'h0d, 8'h0b, 2'h2);
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		rchk(8'h0d, 8'hff, 8'h08);
		rchk(8'h13, 8'h07, 8'h01);
		$display("second reset test done");
	endtask : t_reset2
	initial
	begin
		{rst_n, gpio_is_addr, die_heat_pin, thermal_shutdown_pin} = 4'h0;
		{nv_crc_err, nv_blank, addr_band_pin, rail_good_pin} = 8'h00;
		{ce, bus_idle, secondary_supply_ok_pin} = 3'h7;
		rail_en_seq = 4'hf;
		nv_page_init = 3'h1;
		nv_image = '0;
		nv_image[7:0] = 8'ha5;
		nv_image[111:104] = 8'h08;
		nv_image[119:112] = 8'h21;
		mismatches = 0;
		checks = 0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_reset;
		t_status;
		t_addr;
		t_burn;
		t_rails;
		t_reset2;
		results;
	end
endmodule : pmnv_regs_tb_top
